// *** core/ssr_cfg.svh ***
// constants for the stepper status readout block
`ifndef SSR_CFG_SVH
`define SSR_CFG_SVH

// ----------------------------------------------------------------
// command bytes
// ----------------------------------------------------------------
`define SSR_CMD_FULL      8'h81
`define SSR_CMD_POS       8'hFC
`define SSR_CMD_NVM       8'h82

// ----------------------------------------------------------------
// fixed address byte fields
// ----------------------------------------------------------------
`define SSR_ADDR_ONES2    2'h3
`define SSR_ADDR_ONES3    3'h7
`define SSR_RW_WRITE      1'h0
`define SSR_RW_READ       1'h1

// ----------------------------------------------------------------
// fixed data fields
// ----------------------------------------------------------------
`define SSR_ONES_BYTE     8'hFF
`define SSR_ONE_BIT       1'h1

// ----------------------------------------------------------------
// frame geometry
// ----------------------------------------------------------------
`define SSR_LAST_BIT      3'h7
`define SSR_LAST_BYTE     3'h7
`define SSR_BYTE_LO       3'h0
`define SSR_IDX_STEP      3'h1
`define SSR_BYTE_SHIFT    3'h0
`define SSR_NSYNC         3

`endif

// *** core/ssr_link.sv ***
// bus-clock side of the readout: address match, command capture, byte transmit
`timescale 1ns/10ps
`include "ssr_cfg.svh"

module ssr_link (
	input  wire logic        scl_clk,
	input  wire logic        nrst,
	input  wire logic        sda_in,
	input  wire logic [6:0]  own_addr,
	input  wire logic [63:0] frame,
	output logic             sda_out,
	output logic             sda_oe,
	output logic             cmd_tgl,
	output logic [7:0]       cmd_byte,
	output logic             busy
);
	// ----------------------------------------------------------------
	// start detect: sda falling while scl high
	// ----------------------------------------------------------------
	logic                 start_tgl_r;
	logic                 start_seen_r;
	ssr_pkg::ssr_phase_e  phase_r;
	logic [2:0]           cnt_r;
	logic [2:0]           idx_r;
	logic [6:0]           shift_r;
	logic                 rw_r;
	wire  [7:0]           rx_byte = {shift_r, sda_in};
	wire                  start_new = start_tgl_r ^ start_seen_r;
	wire                  last_bit = (cnt_r == `SSR_LAST_BIT);
	wire                  addr_hit = (rx_byte[7:1] == own_addr);
	wire  [5:0]           base = {~idx_r, `SSR_BYTE_SHIFT};
	wire  [7:0]           tx_byte = frame[base +: 8];

	// relies on the master's start hold time to settle before scl rises
	always_ff @(negedge sda_in or negedge nrst) begin
		if (!nrst) start_tgl_r <= 1'b0;
		else if (scl_clk) start_tgl_r <= ~start_tgl_r;
	end

	// ----------------------------------------------------------------
	// receive and sequence on rising scl
	// ----------------------------------------------------------------
	always_ff @(posedge scl_clk or negedge nrst) begin
		if (!nrst) begin
			start_seen_r <= 1'b0;
			phase_r      <= ssr_pkg::PH_IDLE;
			cnt_r        <= 3'h0;
			idx_r        <= 3'h0;
			shift_r      <= 7'h00;
			rw_r         <= 1'b0;
			cmd_tgl      <= 1'b0;
			cmd_byte     <= 8'h00;
			busy         <= 1'b0;
		end else if (start_new) begin
			start_seen_r <= start_tgl_r;
			phase_r      <= ssr_pkg::PH_ADDR;
			cnt_r        <= `SSR_IDX_STEP;
			shift_r      <= {6'h00, sda_in};
			busy         <= 1'b0;
		end else begin
			shift_r <= rx_byte[6:0];
			cnt_r   <= cnt_r + `SSR_IDX_STEP;
			case (phase_r)
				ssr_pkg::PH_ADDR: if (last_bit) begin
					rw_r    <= rx_byte[0];
					phase_r <= addr_hit ? ssr_pkg::PH_ADDR_ACK : ssr_pkg::PH_IDLE;
				end
				ssr_pkg::PH_ADDR_ACK: begin
					cnt_r   <= 3'h0;
					idx_r   <= `SSR_BYTE_LO;
					busy    <= rw_r;
					phase_r <= rw_r ? ssr_pkg::PH_TX : ssr_pkg::PH_CMD;
				end
				ssr_pkg::PH_CMD: if (last_bit) begin
					cmd_byte <= rx_byte;
					cmd_tgl  <= ~cmd_tgl;
					phase_r  <= ssr_pkg::PH_CMD_ACK;
				end
				ssr_pkg::PH_CMD_ACK: phase_r <= ssr_pkg::PH_IDLE;
				ssr_pkg::PH_TX: if (last_bit) phase_r <= ssr_pkg::PH_TX_ACK;
				ssr_pkg::PH_TX_ACK: begin
					cnt_r <= 3'h0;
					idx_r <= idx_r + `SSR_IDX_STEP;
					if (sda_in || idx_r == `SSR_LAST_BYTE) begin
						phase_r <= ssr_pkg::PH_IDLE;
						busy    <= 1'b0;
					end else phase_r <= ssr_pkg::PH_TX;
				end
				default: phase_r <= ssr_pkg::PH_IDLE;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// drive on falling scl, open drain: enable pulls low
	// ----------------------------------------------------------------
	always_ff @(negedge scl_clk or negedge nrst) begin
		if (!nrst) begin
			sda_out <= 1'b0;
			sda_oe  <= 1'b0;
		end else begin
			sda_out <= 1'b0;
			case (phase_r)
				ssr_pkg::PH_ADDR_ACK: sda_oe <= 1'b1;
				ssr_pkg::PH_CMD_ACK:  sda_oe <= 1'b1;
				ssr_pkg::PH_TX:       sda_oe <= ~tx_byte[~cnt_r];
				default:              sda_oe <= 1'b0;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	property p_read_enters_tx;
		@(posedge scl_clk) disable iff (!nrst)
		(phase_r == ssr_pkg::PH_ADDR_ACK && rw_r && !start_new) |=>
			(phase_r == ssr_pkg::PH_TX && busy && idx_r == 3'h0);
	endproperty
	a_read_enters_tx: assert property (p_read_enters_tx) else $error("read not entered");

	property p_cmd_second_byte;
		@(posedge scl_clk) disable iff (!nrst)
		(phase_r == ssr_pkg::PH_CMD && last_bit && !start_new) |=>
			(phase_r == ssr_pkg::PH_CMD_ACK && cmd_tgl != $past(cmd_tgl) &&
			cmd_byte == $past(rx_byte));
	endproperty
	a_cmd_second_byte: assert property (p_cmd_second_byte) else $error("command misplaced");
endmodule : ssr_link

// *** core/ssr_pkg.sv ***
// types shared by the stepper status readout block
package ssr_pkg;
	// ----------------------------------------------------------------
	// report selection and link phases
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {REP_FULL, REP_POS, REP_NVM} ssr_report_e;
	typedef enum logic [2:0] {
		PH_IDLE, PH_ADDR, PH_ADDR_ACK, PH_CMD, PH_CMD_ACK, PH_TX, PH_TX_ACK
	} ssr_phase_e;
endpackage : ssr_pkg

// *** core/ssr_readout_top.sv ***
// stepper status readout: report assembly, command tracking and flag clear
`timescale 1ns/10ps
`include "ssr_cfg.svh"

module ssr_readout_top (
	input  wire logic                 clk,
	input  wire logic                 nrst,
	// bus pins
	input  wire logic                 scl_clk,
	input  wire logic                 sda_in,
	output logic                      sda_out,
	output logic                      sda_oe,
	// address
	input  wire logic [3:0]           programmable_node_addr,
	input  wire logic                 hardwired_addr_bit,
	// motor parameters
	input  wire logic [3:0]           run_current,
	input  wire logic [3:0]           hold_current,
	input  wire logic [3:0]           max_velocity,
	input  wire logic [3:0]           min_velocity,
	input  wire logic                 no_ramp_enable,
	input  wire logic [1:0]           microstep_setting,
	input  wire logic                 rotation_direction,
	input  wire logic [3:0]           accel_setting,
	// latched faults and status
	input  wire logic                 digital_supply_reset_flag,
	input  wire logic                 lost_steps_flag,
	input  wire logic                 electrical_defect,
	input  wire logic                 battery_undervoltage,
	input  wire logic                 thermal_shutdown,
	input  wire logic                 thermal_warning,
	input  wire logic [1:0]           temperature_info,
	input  wire logic [2:0]           motion_status,
	input  wire logic                 external_switch_state,
	input  wire logic                 x_coil_overcurrent,
	input  wire logic                 y_coil_overcurrent,
	input  wire logic                 stall_flag,
	input  wire logic                 charge_pump_fault,
	input  wire logic [3:0]           absolute_stall_threshold,
	input  wire logic [3:0]           delta_stall_threshold,
	// positions and stall detail
	input  wire logic [15:0]          actual_position,
	input  wire logic [15:0]          target_position,
	input  wire logic [10:0]          secure_position,
	input  wire logic [2:0]           steps_before_detect,
	input  wire logic                 full_duty_flag,
	input  wire logic                 absolute_threshold_trip,
	input  wire logic                 delta_under_trip,
	input  wire logic                 delta_over_trip,
	input  wire logic [2:0]           backemf_sample_delay,
	input  wire logic                 full_duty_detect_off_enable,
	input  wire logic                 pwm_jitter_enable,
	// nonvolatile bytes, location 0 in the top byte
	input  wire logic [63:0]          nvm_bytes,
	// status toward the core
	output logic                      clear_latched_flags,
	output ssr_pkg::ssr_report_e      selected_report,
	output logic [7:0]                last_command,
	output logic                      link_busy
);
	// ----------------------------------------------------------------
	// declarations
	// ----------------------------------------------------------------
	logic [`SSR_NSYNC-1:0]  sync1_r;
	logic [`SSR_NSYNC-1:0]  sync2_r;
	logic                   cmd_seen_r;
	logic                   busy_d_r;
	logic [6:0]             own_addr_r;
	logic [63:0]            frame_r;
	ssr_pkg::ssr_report_e   sel_r;
	ssr_pkg::ssr_report_e   frame_sel_r;
	logic                   clear_r;
	logic [7:0]             last_cmd_r;
	logic                   link_cmd_tgl;
	logic [7:0]             link_cmd_byte;
	logic                   link_busy_raw;
	logic                   link_sda_out;
	logic                   link_sda_oe;

	// ----------------------------------------------------------------
	// command decode
	// ----------------------------------------------------------------
	function automatic logic cmd_valid(input logic [7:0] c);
		cmd_valid = (c == `SSR_CMD_FULL) || (c == `SSR_CMD_POS) || (c == `SSR_CMD_NVM);
	endfunction : cmd_valid

	function automatic ssr_pkg::ssr_report_e cmd_to_report(input logic [7:0] c,
		input ssr_pkg::ssr_report_e keep);
		case (c)
			`SSR_CMD_FULL: cmd_to_report = ssr_pkg::REP_FULL;
			`SSR_CMD_POS:  cmd_to_report = ssr_pkg::REP_POS;
			`SSR_CMD_NVM:  cmd_to_report = ssr_pkg::REP_NVM;
			default:       cmd_to_report = keep;
		endcase
	endfunction : cmd_to_report

	// ----------------------------------------------------------------
	// crossings from the link and the wired address pin
	// ----------------------------------------------------------------
	wire [`SSR_NSYNC-1:0] sync_in = {hardwired_addr_bit, link_busy_raw, link_cmd_tgl};

	genvar gi;
	generate
		for (gi = 0; gi < `SSR_NSYNC; gi = gi + 1) begin : g_sync
			always_ff @(posedge clk or negedge nrst) begin
				if (!nrst) sync1_r[gi] <= 1'b0;
				else sync1_r[gi] <= sync_in[gi];
			end
			always_ff @(posedge clk or negedge nrst) begin
				if (!nrst) sync2_r[gi] <= 1'b0;
				else sync2_r[gi] <= sync1_r[gi];
			end
		end
	endgenerate

	wire cmd_tgl_s = sync2_r[0];
	wire busy_s    = sync2_r[1];
	wire wired_s   = sync2_r[2];
	wire cmd_evt   = cmd_tgl_s ^ cmd_seen_r;
	wire busy_fall = busy_d_r & ~busy_s;

	// cmd byte is held by the link until the next toggle, so it is stable here
	wire                  cmd_ok  = cmd_evt & cmd_valid(link_cmd_byte);
	ssr_pkg::ssr_report_e sel_nxt;
	assign sel_nxt = cmd_evt ? cmd_to_report(link_cmd_byte, sel_r) : sel_r;

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			cmd_seen_r <= 1'b0;
			busy_d_r   <= 1'b0;
		end else begin
			cmd_seen_r <= cmd_tgl_s;
			busy_d_r   <= busy_s;
		end
	end

	// ----------------------------------------------------------------
	// selection, defaults to the full report
	// ----------------------------------------------------------------
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) sel_r <= ssr_pkg::REP_FULL;
		else sel_r <= sel_nxt;
	end

	wire [7:0] last_cmd_nxt = cmd_ok ? link_cmd_byte : last_cmd_r;

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) last_cmd_r <= 8'h00;
		else last_cmd_r <= last_cmd_nxt;
	end

	// ----------------------------------------------------------------
	// own address, compared by the link against the received byte
	// ----------------------------------------------------------------
	wire [6:0] own_addr_nxt = {`SSR_ADDR_ONES2, programmable_node_addr, wired_s};

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) own_addr_r <= 7'h00;
		else own_addr_r <= own_addr_nxt;
	end

	wire [7:0] addr2_byte = {`SSR_ADDR_ONES3, own_addr_r[4:1], own_addr_r[0]};

	// ----------------------------------------------------------------
	// full report bytes
	// ----------------------------------------------------------------
	wire [7:0] full_d1 = {run_current, hold_current};
	wire [7:0] full_d2 = {max_velocity, min_velocity};
	wire [7:0] full_d3 = {no_ramp_enable, microstep_setting, rotation_direction,
		accel_setting};
	wire [7:0] full_d4 = {digital_supply_reset_flag, lost_steps_flag, electrical_defect,
		battery_undervoltage, thermal_shutdown, thermal_warning, temperature_info};
	wire [7:0] full_d5 = {motion_status, external_switch_state, x_coil_overcurrent,
		y_coil_overcurrent, stall_flag, charge_pump_fault};
	wire [7:0] full_d6 = `SSR_ONES_BYTE;
	wire [7:0] full_d7 = {absolute_stall_threshold, delta_stall_threshold};
	wire [63:0] full_frame = {addr2_byte, full_d1, full_d2, full_d3, full_d4, full_d5,
		full_d6, full_d7};

	// ----------------------------------------------------------------
	// position report bytes
	// ----------------------------------------------------------------
	wire [7:0] pos_d5 = secure_position[7:0];
	wire [7:0] pos_d6 = {steps_before_detect, `SSR_ONE_BIT, full_duty_flag,
		secure_position[10:8]};
	wire [7:0] pos_d7 = {absolute_threshold_trip, delta_under_trip, delta_over_trip,
		backemf_sample_delay, full_duty_detect_off_enable, pwm_jitter_enable};
	// positions go out raw; masking low bits per step mode is left to the master
	wire [63:0] pos_frame = {addr2_byte, actual_position, target_position,
		pos_d5, pos_d6, pos_d7};

	// ----------------------------------------------------------------
	// frame snapshot, frozen while the link transmits
	// ----------------------------------------------------------------
	wire [63:0] frame_sel = (sel_r == ssr_pkg::REP_POS) ? pos_frame :
		(sel_r == ssr_pkg::REP_NVM) ? nvm_bytes : full_frame;
	wire [63:0]           frame_nxt = busy_s ? frame_r : frame_sel;
	ssr_pkg::ssr_report_e frame_sel_nxt;
	assign frame_sel_nxt = busy_s ? frame_sel_r : sel_r;

	// the link reads this word only while its own busy is up, well after the freeze
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) frame_r <= 64'h0000_0000_0000_0000;
		else frame_r <= frame_nxt;
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) frame_sel_r <= ssr_pkg::REP_FULL;
		else frame_sel_r <= frame_sel_nxt;
	end

	// ----------------------------------------------------------------
	// flag clear request after a full report
	// ----------------------------------------------------------------
	wire clear_nxt = busy_fall & (frame_sel_r == ssr_pkg::REP_FULL);

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) clear_r <= 1'b0;
		else clear_r <= clear_nxt;
	end

	// ----------------------------------------------------------------
	// link
	// ----------------------------------------------------------------
	ssr_link u_link (
		.scl_clk  (scl_clk),
		.nrst     (nrst),
		.sda_in   (sda_in),
		.own_addr (own_addr_r),
		.frame    (frame_r),
		.sda_out  (link_sda_out),
		.sda_oe   (link_sda_oe),
		.cmd_tgl  (link_cmd_tgl),
		.cmd_byte (link_cmd_byte),
		.busy     (link_busy_raw)
	);

	// ----------------------------------------------------------------
	// outputs
	// ----------------------------------------------------------------
	assign sda_out             = link_sda_out;
	assign sda_oe              = link_sda_oe;
	assign clear_latched_flags = clear_r;
	assign selected_report     = sel_r;
	assign last_command        = last_cmd_r;
	assign link_busy           = busy_d_r;

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	sequence s_full_read_ends;
		busy_fall && frame_sel_r == ssr_pkg::REP_FULL;
	endsequence

	sequence s_single_pulse;
		clear_r ##1 !clear_r;
	endsequence

	property p_clear_after_full;
		@(posedge clk) disable iff (!nrst)
		s_full_read_ends |=> s_single_pulse;
	endproperty
	a_clear_after_full: assert property (p_clear_after_full) else $error("no flag clear");

	property p_clear_only_full;
		@(posedge clk) disable iff (!nrst)
		clear_r |-> $past(busy_fall) && $past(frame_sel_r) == ssr_pkg::REP_FULL;
	endproperty
	a_clear_only_full: assert property (p_clear_only_full) else $error("stray flag clear");

	property p_cmd_selects;
		@(posedge clk) disable iff (!nrst)
		(cmd_evt && link_cmd_byte == `SSR_CMD_POS) |=> sel_r == ssr_pkg::REP_POS;
	endproperty
	a_cmd_selects: assert property (p_cmd_selects) else $error("position not selected");

	property p_bad_cmd_keeps;
		@(posedge clk) disable iff (!nrst)
		(cmd_evt && !cmd_valid(link_cmd_byte)) |=> $stable(sel_r);
	endproperty
	a_bad_cmd_keeps: assert property (p_bad_cmd_keeps) else $error("selection disturbed");

	property p_frozen_in_read;
		@(posedge clk) disable iff (!nrst)
		busy_s |=> $stable(frame_r) && $stable(frame_sel_r);
	endproperty
	a_frozen_in_read: assert property (p_frozen_in_read) else $error("frame moved in read");

	property p_full_fixed_bytes;
		@(posedge clk) disable iff (!nrst)
		(!busy_s && sel_r == ssr_pkg::REP_FULL) |=>
			frame_r[15:8] == `SSR_ONES_BYTE && frame_r[63:61] == `SSR_ADDR_ONES3;
	endproperty
	a_full_fixed_bytes: assert property (p_full_fixed_bytes) else $error("full frame fixed bits");

	property p_pos_layout;
		@(posedge clk) disable iff (!nrst)
		(!busy_s && sel_r == ssr_pkg::REP_POS) |=>
			frame_r[55:40] == $past(actual_position) && frame_r[15:8] == $past(pos_d6) &&
			frame_r[12] == `SSR_ONE_BIT;
	endproperty
	a_pos_layout: assert property (p_pos_layout) else $error("position frame layout");

	property p_nvm_order;
		@(posedge clk) disable iff (!nrst)
		(!busy_s && sel_r == ssr_pkg::REP_NVM) |=> frame_r == $past(nvm_bytes);
	endproperty
	a_nvm_order: assert property (p_nvm_order) else $error("nvm dump order");
endmodule : ssr_readout_top

// *** verif/ssr_master.sv ***
// bus master model for the readout link
`timescale 1ns/10ps

module ssr_master (
	output logic      scl_clk,
	output logic      m_oe,
	input  wire logic sda
);
	// ----------------------------------------------------------------
	// bit timing: 48 ns per bit, clock idles high between frames
	// ----------------------------------------------------------------
	initial begin
		scl_clk = 1'h1;
		m_oe    = 1'h0;
	end
	task automatic bitc(input logic b, output logic r);
		m_oe = ~b;
		#12 scl_clk = 1'h1;
		#12 r = sda;
		#12 scl_clk = 1'h0;
		#12;
	endtask : bitc
	task automatic start();
		m_oe = 1'h0;
		#12 scl_clk = 1'h1;
		#12 m_oe = 1'h1;
		#12 scl_clk = 1'h0;
		#12;
	endtask : start
	task automatic stop();
		m_oe = 1'h1;
		#12 scl_clk = 1'h1;
		#12 m_oe = 1'h0;
		#24;
	endtask : stop
	task automatic wr(input logic [7:0] d, output logic ack);
		for (int i = 7; i >= 0; i--) bitc(d[i], ack);
		bitc(1'h1, ack);
	endtask : wr
	task automatic rd(input logic last, output logic [7:0] d);
		logic r;
		for (int i = 7; i >= 0; i--) bitc(1'h1, d[i]);
		bitc(last, r); // released line on the last byte ends the read
	endtask : rd
endmodule : ssr_master

// *** verif/testbench.sv ***
// self-checking bench for the stepper status readout
`timescale 1ns/10ps
`include "ssr_cfg.svh"

module testbench;
	// ----------------------------------------------------------------
	// wiring
	// ----------------------------------------------------------------
	localparam logic [3:0] NODE = 4'hA;
	logic                  clk  = 1'h0;
	logic                  nrst = 1'h1;
	logic                  hw   = 1'h1;
	logic [55:0]           fr   = 56'hA5_3C96_E75A_00C3;
	logic [55:0]           ps   = 56'h80_01FF_FE34_E5B6;
	logic [63:0]           nv   = 64'h0123_4567_89AB_CDEF;
	logic                  scl_clk, m_oe, sda_oe, sda_out, clr, busy, nak;
	ssr_pkg::ssr_report_e  rep;
	logic [7:0]            lcmd;
	logic [63:0]           rx;
	int                    failures = 0, n_tests = 0, n_clr = 0, cyc = 0;
	wire logic             sda = ~(m_oe | (sda_oe & ~sda_out));
	always #2 clk = ~clk;
	ssr_master u_master (.scl_clk(scl_clk), .m_oe(m_oe), .sda(sda));
	ssr_readout_top u_dut (.clk(clk), .nrst(nrst), .scl_clk(scl_clk), .sda_in(sda),
		.sda_out(sda_out), .sda_oe(sda_oe), .programmable_node_addr(NODE),
		.hardwired_addr_bit(hw), .run_current(fr[55:52]), .hold_current(fr[51:48]),
		.max_velocity(fr[47:44]), .min_velocity(fr[43:40]), .no_ramp_enable(fr[39]),
		.microstep_setting(fr[38:37]), .rotation_direction(fr[36]),
		.accel_setting(fr[35:32]), .digital_supply_reset_flag(fr[31]),
		.lost_steps_flag(fr[30]), .electrical_defect(fr[29]),
		.battery_undervoltage(fr[28]), .thermal_shutdown(fr[27]),
		.thermal_warning(fr[26]), .temperature_info(fr[25:24]),
		.motion_status(fr[23:21]), .external_switch_state(fr[20]),
		.x_coil_overcurrent(fr[19]), .y_coil_overcurrent(fr[18]), .stall_flag(fr[17]),
		.charge_pump_fault(fr[16]), .absolute_stall_threshold(fr[7:4]),
		.delta_stall_threshold(fr[3:0]), .actual_position(ps[55:40]),
		.target_position(ps[39:24]), .secure_position({ps[10:8], ps[23:16]}),
		.steps_before_detect(ps[15:13]), .full_duty_flag(ps[11]),
		.absolute_threshold_trip(ps[7]), .delta_under_trip(ps[6]),
		.delta_over_trip(ps[5]), .backemf_sample_delay(ps[4:2]),
		.full_duty_detect_off_enable(ps[1]), .pwm_jitter_enable(ps[0]),
		.nvm_bytes(nv), .clear_latched_flags(clr), .selected_report(rep),
		.last_command(lcmd), .link_busy(busy));
	always @(posedge clk) if (clr === 1'h1) n_clr++;
	function automatic logic [63:0] fe();
		return {3'h7, NODE, hw, fr[55:16], 8'hFF, fr[7:0]};
	endfunction : fe
	function automatic logic [63:0] pe();
		return {3'h7, NODE, hw, ps[55:13], 1'h1, ps[11:0]};
	endfunction : pe
	task automatic check(input logic [63:0] got, input logic [63:0] exp);
		n_tests++;
		if (got !== exp) begin
			failures++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : check
	task automatic test_done();
		$display("tests=%0d failures=%0d", n_tests, failures);
		if (failures == 0 && n_tests > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask : test_done
	// command frame (optional), read frame, then the clear pulse and selection
	task automatic xfer(input logic [7:0] cmd, input logic wc, input logic [63:0] exp,
			input int clr_n, input ssr_pkg::ssr_report_e rp);
		logic a;
		logic [7:0] b;
		int c0;
		c0 = n_clr;
		if (wc) begin
			u_master.start();
			u_master.wr({2'h3, NODE, hw, `SSR_RW_WRITE}, a);
			check(a, 0);
			u_master.wr(cmd, a);
			check(a, 0);
		end
		u_master.start();
		u_master.wr({2'h3, NODE, hw, `SSR_RW_READ}, a);
		check(a, 0);
		for (int i = 7; i >= 0; i--) begin
			u_master.rd(i == 0, b);
			rx[8*i+:8] = b;
			check(b, exp[8*i+:8]);
		end
		u_master.stop();
		repeat (20) @(posedge clk);
		check(n_clr - c0, clr_n);
		check(rep, rp);
	endtask : xfer
	initial begin
		// a real falling edge, so the bus-clock flops see their reset too
		#1 nrst = 1'h0;
		repeat (10) @(posedge clk);
		#1 nrst = 1'h1;
		repeat (8) @(posedge clk);
		xfer(8'h00, 0, fe(), 1, ssr_pkg::REP_FULL);
		xfer(`SSR_CMD_POS, 1, pe(), 0, ssr_pkg::REP_POS);
		check(rx[55:40] & 16'hFFFE, ps[55:40] & 16'hFFFE);
		xfer(`SSR_CMD_NVM, 1, nv, 0, ssr_pkg::REP_NVM);
		xfer(8'h85, 1, nv, 0, ssr_pkg::REP_NVM);
		check(lcmd, `SSR_CMD_NVM);
		#1 fr = ~fr;
		repeat (4) @(posedge clk);
		xfer(`SSR_CMD_FULL, 1, fe(), 1, ssr_pkg::REP_FULL);
		check(lcmd, `SSR_CMD_FULL);
		#1 hw = 1'h0;
		repeat (4) @(posedge clk);
		xfer(8'h00, 0, fe(), 1, ssr_pkg::REP_FULL);
		u_master.start();
		u_master.wr({2'h3, ~NODE, hw, `SSR_RW_WRITE}, nak);
		check(nak, 1);
		u_master.stop();
		repeat (20) @(posedge clk);
		check(busy, 0);
		test_done();
	end
	// ceiling well above the eleven frames' worth of bus time
	always @(posedge clk) begin
		cyc++;
		if (cyc == 20000) begin
			failures++;
			test_done();
		end
	end
endmodule : testbench
